/* File: inc/fwd_policy_pkg.sv */
// Purpose: shared constants for the switch forwarding-policy block
// Assumes: AHB-Lite register access, 32-bit words, three ports (bit 0 port 1, bit 1 port 2, bit 2 host)
// Notes:   register offsets and field positions are chosen locally
package fwd_policy_pkg;
   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [7:0] OFS_PORT_ONE_CTL  = 8'h00;   // port_one_control_two
   localparam logic [7:0] OFS_PORT_TWO_CTL  = 8'h04;   // port_two_control_two
   localparam logic [7:0] OFS_HOST_CTL      = 8'h08;   // host_port_control_two
   localparam logic [7:0] OFS_GLOBAL_CTL    = 8'h0C;   // switch_global_control_two
   localparam logic [7:0] OFS_STATUS        = 8'h10;   // read-only policy status
   // ***************************************************
   // per-port control field positions
   // ***************************************************
   localparam int BIT_SNIFFER   = 7;   // this port is the sniffer port
   localparam int BIT_RX_SNIFF  = 6;   // mirror packets received here
   localparam int BIT_TX_SNIFF  = 5;   // mirror packets sent here
   localparam int BIT_RX_EN     = 2;   // receive enable
   localparam int BIT_TX_EN     = 1;   // transmit enable
   localparam int BIT_LEARN_DIS = 0;   // learning disable
   // ***************************************************
   // global control field positions
   // ***************************************************
   localparam int BIT_MLD_EN    = 13;  // listener-discovery snooping enable
   localparam int BIT_MLD_OPT   = 12;  // extended next-header option
   localparam int BIT_MIR_AND   = 8;   // mirror only rx-sniffed and tx-sniffed
   localparam int BIT_MIR_BAD   = 0;   // also mirror bad received packets
   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [31:0] RST_NET_CTL    = 32'h0000_0006; // network ports forwarding
   localparam logic [31:0] RST_HOST_CTL   = 32'h0000_0000;
   localparam logic [31:0] RST_GLOBAL_CTL = 32'h0000_0000;
   // ***************************************************
   // port mask and protocol values
   // ***************************************************
   localparam logic [2:0] HOST_MASK   = 3'h4;
   localparam logic [3:0] IP_V4       = 4'h4;
   localparam logic [7:0] PROTO_IGMP  = 8'h02;
   localparam logic [7:0] NH_HOPOPT   = 8'h00;
   localparam logic [7:0] NH_ICMP     = 8'h01;
   localparam logic [7:0] NH_ICMP6    = 8'h3A;
   localparam logic [7:0] NH_ROUTE    = 8'h2B;
   localparam logic [7:0] NH_FRAG     = 8'h2C;
   localparam logic [7:0] NH_ESP      = 8'h32;
   localparam logic [7:0] NH_AUTH     = 8'h33;
   localparam logic [7:0] NH_DSTOPT   = 8'h3C;
   localparam logic [7:0] HOP_ONE     = 8'h01;
endpackage

/* File: core/pkt_classify.sv */
// Purpose: combinational trap classification of a packet header summary
// Assumes: header fields extracted upstream, same clock
// Notes:   purely combinational, registered by the caller
`timescale 1ns/1ns
module pkt_classify (
   // ipv4 summary
   input  wire logic       is_ip4,
   input  wire logic [3:0] ip_version,
   input  wire logic [7:0] ip_proto,
   // ipv6 summary
   input  wire logic       is_ip6_mcast,
   input  wire logic [7:0] hop_limit,
   input  wire logic [7:0] next_hdr,
   input  wire logic [7:0] hbh_next_hdr,
   // controls
   input  wire logic       mld_en,
   input  wire logic       mld_opt,
   // result
   output logic            trap_igmp,
   output logic            trap_mld
);
   logic [7:0] eff_nh;   // next header after optional hop-by-hop
   logic       nh_base;  // icmp or icmpv6
   logic       nh_ext;   // optional extension headers

   // ***************************************************
   // classification
   // ***************************************************
   always_comb begin
      trap_igmp = is_ip4 && ip_version == fwd_policy_pkg::IP_V4
                  && ip_proto == fwd_policy_pkg::PROTO_IGMP;
      eff_nh  = (next_hdr == fwd_policy_pkg::NH_HOPOPT) ? hbh_next_hdr : next_hdr;
      nh_base = eff_nh == fwd_policy_pkg::NH_ICMP || eff_nh == fwd_policy_pkg::NH_ICMP6;
      nh_ext  = mld_opt && (eff_nh == fwd_policy_pkg::NH_ROUTE
                || eff_nh == fwd_policy_pkg::NH_FRAG || eff_nh == fwd_policy_pkg::NH_ESP
                || eff_nh == fwd_policy_pkg::NH_AUTH || eff_nh == fwd_policy_pkg::NH_DSTOPT);
      trap_mld = mld_en && is_ip6_mcast && hop_limit == fwd_policy_pkg::HOP_ONE
                 && (nh_base || nh_ext);
   end
endmodule

/* File: core/ahb_regs.sv */
// Purpose: AHB-Lite slave holding the policy control registers
// Assumes: single word transfers, always OKAY, zero wait states
// Notes:   unmapped reads return zero, unmapped writes are ignored
`timescale 1ns/1ns
module ahb_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // register contents
   output logic [31:0]      ctl_p1,
   output logic [31:0]      ctl_p2,
   output logic [31:0]      ctl_host,
   output logic [31:0]      ctl_glob,
   input  wire logic [31:0] status
);
   logic       wr_pend;  // write data phase pending
   logic [7:0] wr_addr;  // captured write address
   logic       take;     // valid address phase

   assign take = hsel && hready && htrans[1];

   // ***************************************************
   // address phase capture and fixed response
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         // a write is taken only on whole-word transfers; a misaligned address matches no register
         wr_pend   <= take && hwrite && hsize == 3'h2;
         wr_addr   <= take ? haddr[7:0] : wr_addr;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ***************************************************
   // read data, registered during the address phase
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         unique case (haddr[7:0])
            fwd_policy_pkg::OFS_PORT_ONE_CTL: hrdata <= ctl_p1;
            fwd_policy_pkg::OFS_PORT_TWO_CTL: hrdata <= ctl_p2;
            fwd_policy_pkg::OFS_HOST_CTL:     hrdata <= ctl_host;
            fwd_policy_pkg::OFS_GLOBAL_CTL:   hrdata <= ctl_glob;
            fwd_policy_pkg::OFS_STATUS:       hrdata <= status;
            default:                          hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************
   // register writes in the data phase
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_p1   <= fwd_policy_pkg::RST_NET_CTL;
         ctl_p2   <= fwd_policy_pkg::RST_NET_CTL;
         ctl_host <= fwd_policy_pkg::RST_HOST_CTL;
         ctl_glob <= fwd_policy_pkg::RST_GLOBAL_CTL;
      end else if (wr_pend) begin
         if (wr_addr == fwd_policy_pkg::OFS_PORT_ONE_CTL) begin
            ctl_p1 <= hwdata;
         end
         if (wr_addr == fwd_policy_pkg::OFS_PORT_TWO_CTL) begin
            ctl_p2 <= hwdata;
         end
         if (wr_addr == fwd_policy_pkg::OFS_HOST_CTL) begin
            ctl_host <= hwdata;
         end
         if (wr_addr == fwd_policy_pkg::OFS_GLOBAL_CTL) begin
            ctl_glob <= hwdata;
         end
      end
   end
endmodule

/* File: core/fwd_policy.sv */
// Purpose: forwarding policy of a two-network-port switch with a host port
// Assumes: lookup results and header summaries arrive as a one-cycle descriptor
// Notes:   one decision per descriptor, two cycles after it is offered
//
// Contract
// - host port never blocked by port state
// - per network port tx, rx, learn controls
// - disabled: no ordinary traffic, no learning
// - disabled: override static hits reach host
// - blocking: only host-bound packets, no learning
// - listening: only host traffic, no learning
// - learning: host traffic only, learning on
// - forwarding: normal traffic, learning on
// - igmp trapped only to host port
// - igmp is ipv4 protocol two
// - static multicast trimmed to member ports
// - mld trap enabled by global bit
// - mld needs multicast, hop one, icmp
// - option adds extension next headers
// - rx-sniffed packets copied to sniffer
// - option mirrors bad rx packets
// - tx-sniffed packets copied to sniffer
// - and-mode needs rx and tx sniff
// - sniff settings independent per port
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module fwd_policy (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // packet descriptor in
   input  wire logic        pkt_valid,
   input  wire logic [2:0]  pkt_src,
   input  wire logic [2:0]  pkt_lookup,
   input  wire logic        pkt_static_hit,
   input  wire logic        pkt_override,
   input  wire logic        pkt_mcast_static,
   input  wire logic        pkt_bad,
   input  wire logic        is_ip4,
   input  wire logic [3:0]  ip_version,
   input  wire logic [7:0]  ip_proto,
   input  wire logic        is_ip6_mcast,
   input  wire logic [7:0]  hop_limit,
   input  wire logic [7:0]  next_hdr,
   input  wire logic [7:0]  hbh_next_hdr,
   // decision out
   output logic             dec_valid,
   output logic [2:0]       dec_ports,
   output logic             dec_learn,
   output logic             dec_trapped
);
   // ***************************************************
   // declarations
   // ***************************************************
   logic [31:0] ctl_p1;        // port 1 controls
   logic [31:0] ctl_p2;        // port 2 controls
   logic [31:0] ctl_host;      // host port controls
   logic [31:0] ctl_glob;      // global controls
   logic [31:0] status;        // read-back of decision state
   logic [2:0]  tx_en;         // per-port transmit enable
   logic [2:0]  rx_en;         // per-port receive enable
   logic [2:0]  learn_dis;     // per-port learning disable
   logic [2:0]  rx_sniff;      // per-port receive sniff
   logic [2:0]  tx_sniff;      // per-port transmit sniff
   logic [2:0]  sniffer;       // sniffer port select
   logic        trap_igmp;     // igmp detected
   logic        trap_mld;      // mld detected
   logic [2:0]  next_ports;    // egress set before registering
   logic        next_learn;    // learn decision
   logic        next_trap;     // trap decision
   logic        s_valid;       // stage one valid
   logic [2:0]  s_src;         // stage one fields
   logic [2:0]  s_lookup;
   logic        s_static_hit;
   logic        s_override;
   logic        s_mcast_static;
   logic        s_bad;
   logic        s_igmp;
   logic        s_mld;
   logic [2:0]  s_tx_en;       // controls frozen with the packet
   logic [2:0]  s_rx_en;
   logic [2:0]  s_learn_dis;
   logic [7:0]  trap_count;    // traps seen, for status

   // ***************************************************
   // register slave
   // ***************************************************
   ahb_regs u_regs (
      .clk       (clk),
      .rst       (rst),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .ctl_p1    (ctl_p1),
      .ctl_p2    (ctl_p2),
      .ctl_host  (ctl_host),
      .ctl_glob  (ctl_glob),
      .status    (status)
   );

   assign status = {16'h0000, trap_count, 5'h00, dec_ports};

   // ***************************************************
   // per-port control fields
   // ***************************************************
   // independent controls per port
   always_comb begin
      tx_en     = {1'b1, ctl_p2[fwd_policy_pkg::BIT_TX_EN], ctl_p1[fwd_policy_pkg::BIT_TX_EN]};
      rx_en     = {1'b1, ctl_p2[fwd_policy_pkg::BIT_RX_EN], ctl_p1[fwd_policy_pkg::BIT_RX_EN]};
      learn_dis = {1'b0, ctl_p2[fwd_policy_pkg::BIT_LEARN_DIS],
                   ctl_p1[fwd_policy_pkg::BIT_LEARN_DIS]};
      rx_sniff  = {ctl_host[fwd_policy_pkg::BIT_RX_SNIFF], ctl_p2[fwd_policy_pkg::BIT_RX_SNIFF],
                   ctl_p1[fwd_policy_pkg::BIT_RX_SNIFF]};
      tx_sniff  = {ctl_host[fwd_policy_pkg::BIT_TX_SNIFF], ctl_p2[fwd_policy_pkg::BIT_TX_SNIFF],
                   ctl_p1[fwd_policy_pkg::BIT_TX_SNIFF]};
      sniffer   = {ctl_host[fwd_policy_pkg::BIT_SNIFFER], ctl_p2[fwd_policy_pkg::BIT_SNIFFER],
                   ctl_p1[fwd_policy_pkg::BIT_SNIFFER]};
   end

   // ***************************************************
   // trap classifier
   // ***************************************************
   pkt_classify u_cls (
      .is_ip4       (is_ip4),
      .ip_version   (ip_version),
      .ip_proto     (ip_proto),
      .is_ip6_mcast (is_ip6_mcast),
      .hop_limit    (hop_limit),
      .next_hdr     (next_hdr),
      .hbh_next_hdr (hbh_next_hdr),
      .mld_en       (ctl_glob[fwd_policy_pkg::BIT_MLD_EN]),
      .mld_opt      (ctl_glob[fwd_policy_pkg::BIT_MLD_OPT]),
      .trap_igmp    (trap_igmp),
      .trap_mld     (trap_mld)
   );

   // ***************************************************
   // stage one: capture descriptor with its controls
   // ***************************************************
   // tx, rx, learn and mld controls frozen at packet arrival; sniff and mirror-mode controls read at decision
   always_ff @(posedge clk) begin
      if (rst) begin
         s_valid <= 1'b0;
      end else begin
         s_valid <= pkt_valid;
      end
   end

   // descriptor fields and the control snapshot
   always_ff @(posedge clk) begin
      if (rst) begin
         s_src          <= 3'h0;
         s_lookup       <= 3'h0;
         s_static_hit   <= 1'b0;
         s_override     <= 1'b0;
         s_mcast_static <= 1'b0;
         s_bad          <= 1'b0;
         s_igmp         <= 1'b0;
         s_mld          <= 1'b0;
         s_tx_en        <= 3'h0;
         s_rx_en        <= 3'h0;
         s_learn_dis    <= 3'h0;
      end else if (pkt_valid) begin
         s_src          <= pkt_src;
         s_lookup       <= pkt_lookup;
         s_static_hit   <= pkt_static_hit;
         s_override     <= pkt_override;
         s_mcast_static <= pkt_mcast_static;
         s_bad          <= pkt_bad;
         s_igmp         <= trap_igmp;
         s_mld          <= trap_mld;
         s_tx_en        <= tx_en;
         s_rx_en        <= rx_en;
         s_learn_dis    <= learn_dis;
      end
   end

   // ***************************************************
   // decision logic
   // ***************************************************
   always_comb begin
      next_trap  = s_igmp || s_mld;
      next_ports = s_lookup;
      // static multicast already trimmed by lookup set
      if (s_mcast_static) begin
         next_ports = s_lookup;
      end
      if (next_trap) begin
         next_ports = fwd_policy_pkg::HOST_MASK;
      end else if ((s_src & s_rx_en) == 3'h0) begin
         // override static hit still reaches host
         next_ports = (s_static_hit && s_override) ? fwd_policy_pkg::HOST_MASK : 3'h0;
      end else begin
         // egress to transmitting ports, host traffic always passes
         // the host itself also reaches disabled and blocking ports
         next_ports = s_lookup & (s_src[2] ? 3'h7 : s_tx_en) & ~s_src;
      end
      // mirror copy, single delivery via or
      if (next_trap) begin
         // trapped frames keep the host-only set with no mirror copy; the bad-frame rule below still applies
         next_ports = fwd_policy_pkg::HOST_MASK;
      end else if (ctl_glob[fwd_policy_pkg::BIT_MIR_AND]) begin
         if ((s_src & rx_sniff) != 3'h0 && (next_ports & tx_sniff) != 3'h0) begin
            next_ports = next_ports | (sniffer & ~s_src);
         end
      end else if ((s_src & rx_sniff) != 3'h0 || (next_ports & tx_sniff) != 3'h0) begin
         next_ports = next_ports | (sniffer & ~s_src);
      end
      // bad frames dropped unless mirrored by option
      if (s_bad) begin
         next_ports = (ctl_glob[fwd_policy_pkg::BIT_MIR_BAD] && (s_src & rx_sniff) != 3'h0)
                      ? (sniffer & ~s_src) : 3'h0;
      end
      next_learn = !s_bad && (s_src & s_learn_dis) == 3'h0;
   end

   // ***************************************************
   // stage two: registered decision outputs
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         dec_valid   <= 1'b0;
         dec_ports   <= 3'h0;
         dec_learn   <= 1'b0;
         dec_trapped <= 1'b0;
      end else begin
         dec_valid   <= s_valid;
         dec_ports   <= s_valid ? next_ports : 3'h0;
         dec_learn   <= s_valid && next_learn;
         dec_trapped <= s_valid && next_trap;
      end
   end

   // trap counter for status read-back, wraps
   always_ff @(posedge clk) begin
      if (rst) begin
         trap_count <= 8'h00;
      end else if (s_valid && next_trap) begin
         trap_count <= trap_count + 8'h01;
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   sequence pkt_in_trapped;
      pkt_valid && (trap_igmp || trap_mld);
   endsequence

   a_trap_to_host: assert property (@(posedge clk) disable iff (rst)
      pkt_in_trapped |-> ##2 (dec_ports == fwd_policy_pkg::HOST_MASK && dec_trapped))
      else $error("trapped packet not sent only to host");

   a_disabled_drop: assert property (@(posedge clk) disable iff (rst)
      (pkt_valid && (pkt_src & rx_en) == 3'h0 && !pkt_override && !trap_igmp
       && !trap_mld && sniffer == 3'h0) |-> ##2 dec_ports == 3'h0)
      else $error("disabled port forwarded a packet");

   a_override_host: assert property (@(posedge clk) disable iff (rst)
      (pkt_valid && pkt_src == 3'h2 && !rx_en[1] && pkt_static_hit && pkt_override
       && !pkt_bad) |-> ##2 dec_ports[2])
      else $error("override entry did not reach host");

   a_learn_off: assert property (@(posedge clk) disable iff (rst)
      (pkt_valid && (pkt_src & learn_dis) != 3'h0) |-> ##2 !dec_learn)
      else $error("learning on a learning-disabled port");

   a_host_never_block: assert property (@(posedge clk) disable iff (rst)
      (pkt_valid && pkt_src == 3'h1 && rx_en[0] && pkt_lookup == 3'h4 && !pkt_bad
       && !trap_igmp && !trap_mld) |-> ##2 dec_ports[2])
      else $error("host port was blocked");

   a_igmp_detect: assert property (@(posedge clk) disable iff (rst)
      (is_ip4 && ip_version == 4'h4 && ip_proto == 8'h02) |-> trap_igmp)
      else $error("igmp frame not classified");

   a_mld_gate: assert property (@(posedge clk) disable iff (rst)
      !ctl_glob[fwd_policy_pkg::BIT_MLD_EN] |-> !trap_mld)
      else $error("mld trapped while disabled");

   a_rx_mirror: assert property (@(posedge clk) disable iff (rst)
      (pkt_valid && pkt_src == 3'h1 && rx_en[0] && rx_sniff[0] && sniffer == 3'h4
       && !ctl_glob[fwd_policy_pkg::BIT_MIR_AND] && !pkt_bad) |-> ##2 dec_ports[2])
      else $error("rx-sniffed packet not mirrored");

   a_decision_time: assert property (@(posedge clk) disable iff (rst)
      pkt_valid |-> ##1 s_valid ##1 dec_valid)
      else $error("decision not two cycles after descriptor");
endmodule

/* File: tb/host_model.sv */
// Purpose: host processor model, AHB-Lite master of the policy registers
// Assumes: one slave, its hreadyout is hready, single word transfers
// Notes:   waits on hready in each phase, assumes no fixed latency
`timescale 1ns/1ns
module host_model (
   // clock
   input  wire logic        clk,
   // ahb-lite master side
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   // idle bus at time zero
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end
   // host programs port state and global controls
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      // address phase held until accepted
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      // data phase held until accepted
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the forwarding policy block
// Assumes: decision two edges after the descriptor, zero-wait bus
// Notes:   expectations come from port state, trap and mirror settings
`timescale 1ns/1ns
module tb_top;
   // clock, reset, bus and descriptor signals
   logic clk = 0, rst = 1, hsel, hwrite, hreadyout, hresp, hready;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize, pkt_src = 0, pkt_lookup = 0, dec_ports;
   logic pkt_valid = 0, ov = 0, pkt_bad = 0, is_ip4 = 0, is_ip6_mcast = 0;
   logic [3:0]  ip_version = 0;
   logic [7:0]  ip_proto = 0, hop_limit = 0, next_hdr = 0, hbh_next_hdr = 0;
   logic dec_valid, dec_learn, dec_trapped;
   int errors = 0, tests_run = 0;
   localparam logic [7:0] P1 = fwd_policy_pkg::OFS_PORT_ONE_CTL;
   localparam logic [7:0] P2 = fwd_policy_pkg::OFS_PORT_TWO_CTL;
   localparam logic [7:0] PH = fwd_policy_pkg::OFS_HOST_CTL;
   localparam logic [7:0] GL = fwd_policy_pkg::OFS_GLOBAL_CTL;
   localparam logic [37:0] N = 38'h00_0000_0000;
   localparam logic [37:0] G = {1'b1, 4'h4, 8'h02, 25'h000_0000};
   logic [7:0] ext [5] = '{8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C};
   assign hready = hreadyout;
   always #5 clk = ~clk;
   // device and host model
   fwd_policy u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pkt_valid(pkt_valid),
      .pkt_src(pkt_src), .pkt_lookup(pkt_lookup), .pkt_static_hit(ov), .pkt_override(ov),
      .pkt_mcast_static(ov), .pkt_bad(pkt_bad), .is_ip4(is_ip4), .ip_version(ip_version),
      .ip_proto(ip_proto), .is_ip6_mcast(is_ip6_mcast), .hop_limit(hop_limit),
      .next_hdr(next_hdr), .hbh_next_hdr(hbh_next_hdr), .dec_valid(dec_valid),
      .dec_ports(dec_ports), .dec_learn(dec_learn), .dec_trapped(dec_trapped));
   host_model host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
   // compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // register access
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      host.xfer(1'b0, a, 32'h0000_0000, q);
      chk(q, x);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask
   // one descriptor, then its decision {ports, learn, trap}
   task automatic pk(input logic [2:0] s, l, input logic o, b, input logic [37:0] h,
                     input logic [2:0] p, input logic [1:0] lt);
      @(posedge clk);
      pkt_valid <= 1'b1;
      pkt_src <= s;
      pkt_lookup <= l;
      ov <= o;
      pkt_bad <= b;
      {is_ip4, ip_version, ip_proto, is_ip6_mcast, hop_limit, next_hdr, hbh_next_hdr} <= h;
      @(posedge clk);
      pkt_valid <= 1'b0;
      @(posedge clk);
      #1 chk({dec_valid, dec_ports, dec_learn, dec_trapped}, {1'b1, p, lt});
   endtask
   // ipv6 header summary
   function automatic logic [37:0] m6(input logic [7:0] n, hb, hl);
      return {13'h0000, 1'b1, hl, n, hb};
   endfunction
   // verdict and end of run
   task automatic give_verdict;
      if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      #100000 errors++;
      give_verdict;
   end
   // ************************************
   // test sequence
   // ************************************
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(P1, fwd_policy_pkg::RST_NET_CTL);
      rd(PH, fwd_policy_pkg::RST_HOST_CTL);
      rd(8'h20, 32'h0000_0000);
      pk(3'h1, 3'h2, 0, 0, N, 3'h2, 2'h2);
      pk(3'h4, 3'h1, 0, 0, N, 3'h1, 2'h2);
      // port one sends nothing toward the disabled port, which drops its frames except override static hits, which reach the host
      wr(P2, 32'h0000_0001);
      rd(P2, 32'h0000_0001);
      pk(3'h1, 3'h2, 0, 0, N, 3'h0, 2'h2);
      pk(3'h2, 3'h1, 0, 0, N, 3'h0, 2'h0);
      pk(3'h2, 3'h4, 1, 0, N, 3'h4, 2'h0);
      wr(P2, 32'h0000_0000);
      pk(3'h2, 3'h1, 0, 0, N, 3'h0, 2'h2);
      pk(3'h2, 3'h4, 1, 0, N, 3'h4, 2'h2);
      pk(3'h4, 3'h2, 0, 0, N, 3'h2, 2'h2);
      wr(P2, 32'h0000_0006);
      pk(3'h1, 3'h6, 1, 0, N, 3'h6, 2'h2);
      pk(3'h1, 3'h2, 0, 0, G, 3'h4, 2'h3);
      pk(3'h1, 3'h2, 0, 0, G ^ 38'h00_0300_0000, 3'h2, 2'h2);
      pk(3'h1, 3'h2, 0, 0, m6(8'h3A, 8'h00, 8'h01), 3'h2, 2'h2);
      wr(GL, 32'h0000_2000);
      pk(3'h1, 3'h2, 0, 0, m6(8'h3A, 8'h00, 8'h01), 3'h4, 2'h3);
      pk(3'h1, 3'h2, 0, 0, m6(8'h00, 8'h01, 8'h01), 3'h4, 2'h3);
      pk(3'h1, 3'h2, 0, 0, m6(8'h3A, 8'h00, 8'h02), 3'h2, 2'h2);
      pk(3'h1, 3'h2, 0, 0, m6(8'h2B, 8'h00, 8'h01), 3'h2, 2'h2);
      wr(GL, 32'h0000_3000);
      foreach (ext[i]) pk(3'h1, 3'h2, 0, 0, m6(ext[i], 8'h00, 8'h01), 3'h4, 2'h3);
      pk(3'h1, 3'h2, 0, 0, m6(8'h00, 8'h3C, 8'h01), 3'h4, 2'h3);
      rd(fwd_policy_pkg::OFS_STATUS, 32'h0000_0900);
      // host is sniffer, port one receive-sniffed
      wr(GL, 32'h0000_0000);
      wr(PH, 32'h0000_0080);
      wr(P1, 32'h0000_0046);
      pk(3'h1, 3'h2, 0, 0, N, 3'h6, 2'h2);
      pk(3'h1, 3'h4, 0, 0, N, 3'h4, 2'h2);
      pk(3'h2, 3'h1, 0, 0, N, 3'h1, 2'h2);
      pk(3'h1, 3'h2, 0, 1, N, 3'h0, 2'h0);
      wr(GL, 32'h0000_0001);
      pk(3'h1, 3'h2, 0, 1, N, 3'h4, 2'h0);
      wr(P1, 32'h0000_0006);
      wr(P2, 32'h0000_0026);
      pk(3'h1, 3'h2, 0, 0, N, 3'h6, 2'h2);
      wr(GL, 32'h0000_0100);
      pk(3'h1, 3'h2, 0, 0, N, 3'h2, 2'h2);
      wr(P1, 32'h0000_0046);
      pk(3'h1, 3'h2, 0, 0, N, 3'h6, 2'h2);
      wr(P2, 32'h0000_0006);
      pk(3'h1, 3'h2, 0, 0, N, 3'h2, 2'h2);
      give_verdict;
   end
endmodule
